// ===== serial_break_idle.sv
// serial transceiver with break, queued idle and receive framing
`timescale 1ns/10ps
// Function
// (RULE1) tx keeps pin until queued work ends
// (RULE2) break is one character of continuous low
// (RULE3) setting send break queues one break
// (RULE4) break still set at load queues another
// (RULE5) break length 10/11/13/14 from selects
// (RULE6) received break gives zeros and framing error
// (RULE7) software waits for empty before break
// (RULE8) empty flag sets when data enters shifter
// (RULE9) sender leaves idle character between messages
// (RULE10) enable clear-then-set queues one idle character
// (RULE11) pin not released while work pending; code takes it a cycle late for a break queued with tx off
// (RULE12) software drives port high if released
// (RULE13) receive invert applies before framing
// (RULE14) receiver runs only while enabled
// (RULE15) frame is start, data lsb first, stop
// (RULE16) load receive data only when not full
// (RULE17) transfer sets full flag until read
// (RULE18) full register on completion means overrun
module serial_break_idle
    import serial_pkg::*;
#(
    parameter logic [15:0] BAUD_INIT = BAUD_RESET
)(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rxd,
    output logic txd,
    output logic txd_oe,
    output logic irq
);
    function automatic logic [3:0] char_bits(input logic nine,
                                             input logic longb);
        char_bits = BASE_BITS + {3'h0, nine} + (longb ? LONG_EXTRA : 4'h0);
    endfunction

    ctrl_s ctrl, next_ctrl, wr_ctrl;
    evt_s ev, next_ev, mask, next_mask, new_ev;
    logic [15:0] baud_div, next_baud_div, bcnt, next_bcnt;
    logic [15:0] rcnt, next_rcnt;
    logic wr_pend, next_wr_pend;
    logic [7:0] wr_addr, next_wr_addr;
    logic [31:0] next_hrdata;
    tx_e tx_state, next_tx_state;
    rx_e rx_state, next_rx_state;
    logic [10:0] tx_shift, next_tx_shift;
    logic [3:0] tx_cnt, next_tx_cnt, rbit, next_rbit;
    logic brk_q, next_brk_q, idle_q, next_idle_q;
    logic [8:0] tdr, next_tdr, rshift, next_rshift, rdr, next_rdr;
    logic tx_data_empty_flag, next_tx_data_empty_flag, rx_data_full_flag, next_rx_data_full_flag;
    logic tx_own, next_tx_own;
    logic rx_sync1, rx_sync2, rx_in;
    logic ap_valid, tick, tx_slot, ctrl_wr, tdr_wr;
    logic load_brk, load_idle, load_data, rx_done;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign txd = tx_shift[0];
    assign txd_oe = tx_own;
    assign irq = |(ev & mask);
    assign rx_in = rx_sync2 ^ ctrl.rx_invert_ctl; // RULE13
    assign ap_valid = hsel && hready && (htrans == HTRANS_NONSEQ
                      || htrans == 2'h3) && (hsize <= 3'h2);
    assign wr_ctrl = ctrl_s'(hwdata[CTRL_W-1:0]);
    assign ctrl_wr = wr_pend && wr_addr == OFS_CTRL;
    assign tdr_wr = wr_pend && wr_addr == OFS_TXDATA;
    assign tick = bcnt == 16'h0000;
    assign tx_slot = tick && (tx_state == TX_FREE || tx_cnt == 4'h1);
    assign load_brk = tx_slot && brk_q;
    assign load_idle = tx_slot && !brk_q && idle_q;
    assign load_data = tx_slot && !brk_q && !idle_q
                       && ctrl.tx_enable_bit && !tx_data_empty_flag;
    assign rx_done = rx_state == RX_STOP && rcnt == 16'h0000;

    always_comb
    begin
        next_ctrl = ctrl;
        next_mask = mask;
        next_baud_div = baud_div;
        next_wr_pend = ap_valid && hwrite;
        next_wr_addr = haddr[7:0];
        next_hrdata = hrdata;
        next_tdr = tdr;
        next_tx_data_empty_flag = tx_data_empty_flag;
        next_rdr = rdr;
        next_rx_data_full_flag = rx_data_full_flag;
        new_ev = EV_NONE;
        next_ev = ev;
        next_bcnt = tick ? baud_div - 16'h0001 : bcnt - 16'h0001;
        next_brk_q = brk_q;
        next_idle_q = idle_q;
        next_tx_state = tx_state;
        next_tx_shift = tx_shift;
        next_tx_cnt = tx_cnt;
        next_rx_state = rx_state;
        next_rcnt = rcnt;
        next_rbit = rbit;
        next_rshift = rshift;
        // transmitter: queued break first, then idle, then data
        if (load_brk)
        begin
            next_tx_state = TX_BREAK;
            next_tx_shift = SHIFT_SPACE; // RULE2
            next_tx_cnt = char_bits(ctrl.nine_bit_sel,
                                    ctrl.long_break_sel); // RULE5
            next_brk_q = ctrl.send_break_ctl; // RULE4
        end
        else if (load_idle)
        begin
            next_tx_state = TX_MARK;
            next_tx_shift = SHIFT_MARK;
            next_tx_cnt = char_bits(ctrl.nine_bit_sel, 1'b0);
            next_idle_q = 1'b0;
        end
        else if (load_data)
        begin
            next_tx_state = TX_DATA;
            next_tx_shift = ctrl.nine_bit_sel
                ? {1'b1, tdr, 1'b0} : {2'b11, tdr[7:0], 1'b0}; // RULE15
            next_tx_cnt = char_bits(ctrl.nine_bit_sel, 1'b0);
            next_tx_data_empty_flag = 1'b1; // RULE8
            new_ev.tx_empty = 1'b1;
        end
        else if (tx_slot)
        begin
            next_tx_state = TX_FREE;
            next_tx_shift = SHIFT_MARK;
            next_tx_cnt = 4'h0;
        end
        else if (tick && tx_state != TX_FREE)
        begin
            // break keeps filling with low so long breaks stay low
            next_tx_shift = {tx_state != TX_BREAK, tx_shift[10:1]};
            next_tx_cnt = tx_cnt - 4'h1;
        end
        // pin is ours while anything shifts or is queued, bar the first cycle of a break queued with tx off
        next_tx_own = next_ctrl.tx_enable_bit || next_tx_state != TX_FREE
                      || next_brk_q || next_idle_q; // RULE1 RULE11
        // receiver
        if (!ctrl.rx_enable_bit)
        begin
            next_rx_state = RX_HUNT; // RULE14
        end
        else
        begin
            next_rcnt = rcnt - 16'h0001;
            case (rx_state)
                RX_HUNT:
                begin
                    if (!rx_in)
                    begin
                        next_rx_state = RX_START;
                        next_rcnt = {1'b0, baud_div[15:1]};
                        next_rshift = 9'h000;
                    end
                end
                RX_START:
                begin
                    if (rcnt == 16'h0000)
                    begin
                        // a start bit gone high by mid-bit was a glitch
                        next_rx_state = rx_in ? RX_HUNT : RX_BITS;
                        next_rcnt = baud_div - 16'h0001;
                        next_rbit = 4'h0;
                    end
                end
                RX_BITS:
                begin
                    if (rcnt == 16'h0000)
                    begin
                        next_rshift[rbit] = rx_in; // RULE15
                        next_rbit = rbit + 4'h1;
                        next_rcnt = baud_div - 16'h0001;
                        if (rbit == (ctrl.nine_bit_sel ? 4'h8 : 4'h7))
                        begin
                            next_rx_state = RX_STOP;
                        end
                    end
                end
                RX_STOP:
                begin
                    if (rcnt == 16'h0000)
                    begin
                        next_rx_state = RX_HUNT;
                    end
                end
                default:
                begin
                    next_rx_state = RX_HUNT;
                end
            endcase
        end
        if (rx_done && ctrl.rx_enable_bit)
        begin
            new_ev.framing = !rx_in; // RULE6
            if (rx_data_full_flag)
            begin
                new_ev.overrun = 1'b1; // RULE18
            end
            else
            begin
                next_rdr = rshift; // RULE16
                next_rx_data_full_flag = 1'b1; // RULE17
                new_ev.rx_full = 1'b1;
            end
        end
        // bus: reads answer and clear at the address phase
        if (ap_valid && !hwrite)
        begin
            case (haddr[7:0])
                OFS_CTRL: next_hrdata = {26'h0, ctrl};
                OFS_BAUD: next_hrdata = {16'h0, baud_div};
                OFS_TXDATA: next_hrdata = {23'h0, tdr};
                OFS_RXDATA: next_hrdata = {23'h0, rdr};
                OFS_FLAGS: next_hrdata = {29'h0, tx_own, rx_data_full_flag, tx_data_empty_flag};
                OFS_EVENTS: next_hrdata = {28'h0, ev};
                OFS_MASK: next_hrdata = {28'h0, mask};
                default: next_hrdata = 32'h0000_0000;
            endcase
            if (haddr[7:0] == OFS_RXDATA && !new_ev.rx_full)
            begin
                next_rx_data_full_flag = 1'b0; // RULE17
            end
            if (haddr[7:0] == OFS_EVENTS)
            begin
                next_ev = EV_NONE;
            end
        end
        next_ev = next_ev | new_ev;
        if (ctrl_wr)
        begin
            next_ctrl = wr_ctrl;
            if (wr_ctrl.send_break_ctl && !ctrl.send_break_ctl)
            begin
                next_brk_q = 1'b1; // RULE3
            end
            if (wr_ctrl.tx_enable_bit && !ctrl.tx_enable_bit)
            begin
                next_idle_q = 1'b1; // RULE10
            end
            next_tx_own = next_tx_own || wr_ctrl.tx_enable_bit;
        end
        if (wr_pend && wr_addr == OFS_BAUD)
        begin
            next_baud_div = hwdata[15:0];
        end
        if (tdr_wr)
        begin
            next_tdr = hwdata[8:0];
            next_tx_data_empty_flag = 1'b0;
        end
        if (wr_pend && wr_addr == OFS_MASK)
        begin
            next_mask = evt_s'(hwdata[EV_W-1:0]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl <= CTRL_RESET;
            mask <= EV_NONE;
            ev <= EV_NONE;
            baud_div <= BAUD_INIT;
            bcnt <= 16'h0000;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
            tdr <= 9'h000;
            tx_data_empty_flag <= 1'b1;
            rdr <= 9'h000;
            rx_data_full_flag <= 1'b0;
            brk_q <= 1'b0;
            idle_q <= 1'b0;
            tx_state <= TX_FREE;
            tx_shift <= SHIFT_MARK;
            tx_cnt <= 4'h0;
            tx_own <= 1'b0;
            rx_state <= RX_HUNT;
            rcnt <= 16'h0000;
            rbit <= 4'h0;
            rshift <= 9'h000;
            rx_sync1 <= 1'b1;
            rx_sync2 <= 1'b1;
        end
        else
        begin
            ctrl <= next_ctrl;
            mask <= next_mask;
            ev <= next_ev;
            baud_div <= next_baud_div;
            bcnt <= next_bcnt;
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata <= next_hrdata;
            tdr <= next_tdr;
            tx_data_empty_flag <= next_tx_data_empty_flag;
            rdr <= next_rdr;
            rx_data_full_flag <= next_rx_data_full_flag;
            brk_q <= next_brk_q;
            idle_q <= next_idle_q;
            tx_state <= next_tx_state;
            tx_shift <= next_tx_shift;
            tx_cnt <= next_tx_cnt;
            tx_own <= next_tx_own;
            rx_state <= next_rx_state;
            rcnt <= next_rcnt;
            rbit <= next_rbit;
            rshift <= next_rshift;
            rx_sync1 <= rxd;
            rx_sync2 <= rx_sync1;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_break_loaded;
        ##1 brk_q ##1 (tx_state == TX_BREAK);
    endsequence

    a_break_low: assert property ((tx_state == TX_BREAK) |-> !txd) // RULE2
        else $error("break character not low");
    a_break_length: assert property ($rose(tx_state == TX_BREAK) |->
        tx_cnt == char_bits($past(ctrl.nine_bit_sel),
                            $past(ctrl.long_break_sel))) // RULE5
        else $error("break length wrong");
    a_break_queue: assert property ((ctrl_wr && wr_ctrl.send_break_ctl
        && !ctrl.send_break_ctl) |=> brk_q) // RULE3
        else $error("break not queued");
    a_break_requeue: assert property ((load_brk && ctrl.send_break_ctl
        && !ctrl_wr) |-> s_break_loaded) // RULE4
        else $error("held break not queued again");
    a_idle_queue: assert property ((ctrl_wr && wr_ctrl.tx_enable_bit
        && !ctrl.tx_enable_bit) |=> idle_q) // RULE10
        else $error("idle not queued");
    a_pin_held: assert property ((tx_state != TX_FREE || brk_q || idle_q)
        |-> tx_own) // RULE1 RULE11
        else $error("pin released with work pending");
    a_empty_set: assert property ((load_data && !tdr_wr) |=>
        tx_data_empty_flag && tx_state == TX_DATA && !txd) // RULE8 RULE15
        else $error("empty flag or start bit wrong");
    a_rx_enable: assert property (!ctrl.rx_enable_bit |=>
        rx_state == RX_HUNT) // RULE14
        else $error("receiver ran while disabled");
    a_rx_invert: assert property ((rx_state == RX_HUNT && ctrl.rx_enable_bit
        && rx_sync2 == ctrl.rx_invert_ctl) |=> rx_state == RX_START) // RULE13
        else $error("inverted start not seen");
    a_rx_load: assert property ((rx_done && ctrl.rx_enable_bit && !rx_data_full_flag)
        |=> rx_data_full_flag && rdr == $past(rshift) && ev.rx_full) // RULE16 RULE17
        else $error("received character not loaded");
    a_rx_overrun: assert property ((rx_done && ctrl.rx_enable_bit && rx_data_full_flag)
        |=> rdr == $past(rdr) && ev.overrun) // RULE18
        else $error("overrun not handled");
    a_rx_break: assert property ((rx_done && ctrl.rx_enable_bit && !rx_in)
        |=> ev.framing) // RULE6
        else $error("framing error missing");
endmodule // serial_break_idle

// ===== serial_break_idle_and_rx_framing_tb_top.sv
// self-checking bench for the serial break/idle transceiver
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
num_errors++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
end end
`define WAITC(c) begin for (int k = 0; k < 3000 && !(c); k++) \
@(posedge hclk); if (!(c)) num_errors++; end
module serial_break_idle_and_rx_framing_tb_top;
    import serial_pkg::*;
    localparam int BIT = 8;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready, hreadyout, hresp, txd, txd_oe, irq, rxd;
    logic inv = 1'b0;
    logic [31:0] rdata, hrdata_w;
    logic line_tx;
    logic [7:0] d, d2;
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n, r0;
    // single slave, so its ready is the bus ready
    assign hready = hreadyout;
    serial_break_idle #(.BAUD_INIT(16'h0008)) dut (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata_w),
        .rxd(rxd), .txd(txd), .txd_oe(txd_oe), .irq(irq));
    // port pin set to drive high whenever the transmitter lets go
    assign line_tx = txd_oe ? txd : 1'b1;
    serial_peer #(.BIT(BIT)) peer (.hclk(hclk), .txd(line_tx), .inv(inv),
        .rxd(rxd));
    initial
    begin
        forever #12.5 hclk = ~hclk;
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rdata = hrdata_w;
        hsel <= 1'b0;
    endtask
    // poll until the shifter has taken the last written character
    task automatic wait_empty();
        int t;
        t = 0;
        do
        begin
            bus(1'b0, OFS_FLAGS, 32'h0);
            t++;
        end
        while (rdata[0] !== 1'b1 && t < 200);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    function automatic int brk_len(input logic lb, input logic nb);
        return 10 + (nb ? 1 : 0) + (lb ? 3 : 0);
    endfunction
    logic [7:0] ra [6] = '{OFS_CTRL, OFS_BAUD, OFS_MASK, OFS_EVENTS,
        OFS_FLAGS, 8'h1C};
    logic [31:0] rv [6] = '{32'h0, 32'h8, 32'h0, 32'h0, 32'h1, 32'h0};
    initial
    begin
        void'($urandom(32'h64a1));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        `CHK("txd_oe", 1'b0, txd_oe)
        `CHK("txd", 1'b1, txd)
        `CHK("hreadyout", 1'b1, hreadyout)
        `CHK("hresp", 1'b0, hresp)
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b0, ra[i], 32'h0);
            `CHK("reset value", rv[i], rdata)
        end
        bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
        bus(1'b0, 8'h1C, 32'h0);
        `CHK("unmapped", 32'h0, rdata)
        done("registers");
        // idle char must precede data written right after enable
        bus(1'b1, OFS_CTRL, 32'h1);
        d = 8'($urandom);
        bus(1'b1, OFS_TXDATA, {24'h0, d});
        n = 0;
        while (txd !== 1'b0 && n < 2000)
        begin
            @(posedge hclk);
            n++;
        end
        `CHK("idle first", 1'b1, n >= 70)
        r0 = peer.frames;
        `WAITC(peer.frames != r0)
        `CHK("tx byte", d, peer.got)
        bus(1'b0, OFS_FLAGS, 32'h0);
        `CHK("tx empty", 1'b1, rdata[0])
        done("idle");
        d2 = 8'($urandom);
        bus(1'b1, OFS_TXDATA, {24'h0, d2});
        // clear enable only once the character sits in the shifter
        wait_empty();
        bus(1'b1, OFS_CTRL, 32'h0);
        `CHK("pin kept", 1'b1, txd_oe)
        r0 = peer.frames;
        `WAITC(peer.frames != r0)
        `CHK("tx byte", d2, peer.got)
        repeat (20) @(posedge hclk);
        `CHK("pin freed", 1'b0, txd_oe)
        done("disable");
        bus(1'b1, OFS_CTRL, 32'h1);
        for (int j = 0; j < 4; j++)
        begin
            // all-ones data: only its start bit is low, then the break
            r0 = peer.runs;
            bus(1'b1, OFS_TXDATA, 32'h0000_01FF);
            wait_empty();
            `CHK("empty first", 1'b1, rdata[0])
            bus(1'b1, OFS_CTRL, {27'h0, j[0], j[1], 3'b101});
            bus(1'b1, OFS_CTRL, {27'h0, j[0], j[1], 3'b001});
            `WAITC(peer.runs == r0 + 2)
            `CHK("break", BIT * brk_len(j[1], j[0]), peer.low_run)
        end
        r0 = peer.runs;
        bus(1'b1, OFS_CTRL, 32'h5);
        repeat (150) @(posedge hclk);
        bus(1'b1, OFS_CTRL, 32'h1);
        `WAITC(peer.runs != r0)
        n = peer.low_run;
        `CHK("break again", 1'b1, n >= 2 * 10 * BIT)
        done("break");
        bus(1'b1, OFS_CTRL, 32'h2);
        bus(1'b1, OFS_MASK, 32'h2);
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b0, OFS_EVENTS, 32'h0);
            d = 8'($urandom);
            peer.send(d, 1'b1);
            `CHK("irq set", 1'b1, irq)
            bus(1'b0, OFS_EVENTS, 32'h0);
            `CHK("rx event", 1'b1, rdata[1])
            repeat (2) @(posedge hclk);
            `CHK("irq clear", 1'b0, irq)
            bus(1'b0, OFS_RXDATA, 32'h0);
            `CHK("rx byte", d, rdata[7:0])
            bus(1'b0, OFS_FLAGS, 32'h0);
            `CHK("full clear", 1'b0, rdata[1])
        end
        d = 8'($urandom);
        d2 = ~d;
        peer.send(d, 1'b1);
        peer.send(d2, 1'b1);
        bus(1'b0, OFS_RXDATA, 32'h0);
        `CHK("old kept", d, rdata[7:0])
        bus(1'b0, OFS_EVENTS, 32'h0);
        `CHK("overrun", 1'b1, rdata[3])
        peer.send(8'h00, 1'b0);
        bus(1'b0, OFS_RXDATA, 32'h0);
        `CHK("break data", 8'h00, rdata[7:0])
        bus(1'b0, OFS_EVENTS, 32'h0);
        `CHK("framing", 1'b1, rdata[2])
        done("receive");
        bus(1'b1, OFS_CTRL, 32'h0);
        peer.send(8'($urandom), 1'b1);
        bus(1'b0, OFS_FLAGS, 32'h0);
        `CHK("rx off", 1'b0, rdata[1])
        // flip the line only while the receiver is off
        bus(1'b1, OFS_CTRL, 32'h20);
        inv <= 1'b1;
        bus(1'b1, OFS_CTRL, 32'h22);
        d = 8'($urandom);
        peer.send(d, 1'b1);
        bus(1'b0, OFS_RXDATA, 32'h0);
        `CHK("inverted", d, rdata[7:0])
        done("invert");
        print_verdict();
    end
endmodule // serial_break_idle_and_rx_framing_tb_top

// ===== serial_peer.sv
// remote serial node: decodes txd, sends frames on rxd
`timescale 1ns/10ps
module serial_peer #(
    parameter int BIT = 8
)(
    input wire logic hclk,
    input wire logic txd,
    input wire logic inv,
    output logic rxd
);
    logic [7:0] got = 8'h00;
    logic line = 1'b1;
    int frames = 0;
    int run = 0;
    int low_run = 0;
    int runs = 0;
    // idle line is high; inv models a line seen through an inverter
    assign rxd = line ^ inv;
    always @(posedge hclk)
    begin
        if (txd === 1'b0)
            run <= run + 1;
        else if (run != 0)
        begin
            low_run <= run;
            runs <= runs + 1;
            run <= 0;
        end
    end
    initial
    begin
        forever
        begin
            @(negedge txd);
            repeat (BIT / 2) @(posedge hclk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT) @(posedge hclk);
                got[i] = txd;
            end
            repeat (BIT) @(posedge hclk);
            frames++;
        end
    end
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            line <= f[i];
            repeat (BIT) @(posedge hclk);
        end
        line <= 1'b1;
        // a full idle character before the next message
        repeat (10 * BIT) @(posedge hclk);
    endtask
endmodule // serial_peer

// ===== serial_pkg.sv
// constants and carriers for the serial break/idle transceiver
package serial_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BAUD = 8'h04;
    localparam logic [7:0] OFS_TXDATA = 8'h08;
    localparam logic [7:0] OFS_RXDATA = 8'h0C;
    localparam logic [7:0] OFS_FLAGS = 8'h10;
    localparam logic [7:0] OFS_EVENTS = 8'h14;
    localparam logic [7:0] OFS_MASK = 8'h18;
    localparam int CTRL_W = 6;
    localparam int EV_W = 4;
    localparam logic [3:0] BASE_BITS = 4'hA;
    localparam logic [3:0] LONG_EXTRA = 4'h3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam int CLK_HZ = 40_000_000;
    localparam int BAUD_HZ = 9_600;
    localparam int BAUD_DIV = (CLK_HZ + BAUD_HZ / 2) / BAUD_HZ;
    localparam logic [15:0] BAUD_RESET = 16'(BAUD_DIV);
    localparam logic [10:0] SHIFT_MARK = 11'h7FF;
    localparam logic [10:0] SHIFT_SPACE = 11'h000;

    typedef struct packed {
        logic rx_invert_ctl;
        logic nine_bit_sel;
        logic long_break_sel;
        logic send_break_ctl;
        logic rx_enable_bit;
        logic tx_enable_bit;
    } ctrl_s;

    typedef struct packed {
        logic overrun;
        logic framing;
        logic rx_full;
        logic tx_empty;
    } evt_s;

    localparam ctrl_s CTRL_RESET = ctrl_s'(6'h00);
    localparam evt_s EV_NONE = evt_s'(4'h0);

    typedef enum logic [3:0] {
        TX_FREE = 4'b0001,
        TX_DATA = 4'b0010,
        TX_BREAK = 4'b0100,
        TX_MARK = 4'b1000
    } tx_e;

    typedef enum logic [3:0] {
        RX_HUNT = 4'b0001,
        RX_START = 4'b0010,
        RX_BITS = 4'b0100,
        RX_STOP = 4'b1000
    } rx_e;
endpackage
